//--- core/crt_pkg.sv
// Purpose: shared constants for the raster timing generator
// Assumes: 40 MHz ref_clk used as the pixel clock
// Notes: register offsets are word indices on the plain register port
package crt_pkg;
	localparam int unsigned crt_addr_w = 5;
	localparam logic [4:0] crt_off_h_total = 5'h00;
	localparam logic [4:0] crt_off_h_disp_end = 5'h01;
	localparam logic [4:0] crt_off_h_blank_start = 5'h02;
	localparam logic [4:0] crt_off_h_blank_end = 5'h03;
	localparam logic [4:0] crt_off_h_sync_start = 5'h04;
	localparam logic [4:0] crt_off_h_sync_end = 5'h05;
	localparam logic [4:0] crt_off_v_total = 5'h06;
	localparam logic [4:0] crt_off_v_ext = 5'h07;
	localparam logic [4:0] crt_off_v_sync_start = 5'h10;
	localparam logic [4:0] crt_off_v_sync_end = 5'h11;
	localparam logic [4:0] crt_off_v_disp_end = 5'h12;
	localparam logic [4:0] crt_off_v_blank_start = 5'h15;
	localparam logic [4:0] crt_off_v_blank_end = 5'h16;
	localparam logic [4:0] crt_off_misc_output = 5'h18;
	localparam logic [4:0] crt_off_power_mgmt = 5'h19;
	localparam logic [4:0] crt_off_status = 5'h1a;
	localparam logic [4:0] crt_off_h_count = 5'h1b;
	localparam logic [4:0] crt_off_v_count_lo = 5'h1c;
	localparam logic [4:0] crt_off_v_count_hi = 5'h1d;
	// counter widths and compare widths of the short end comparisons
	localparam int unsigned crt_h_w = 8;
	localparam int unsigned crt_v_w = 10;
	localparam int unsigned crt_h_sync_end_w = 5;
	localparam int unsigned crt_h_blank_end_w = 6;
	localparam int unsigned crt_v_sync_end_w = 4;
	localparam int unsigned crt_v_blank_end_w = 8;
	localparam int unsigned crt_pix_per_char = 8;
	// vertical extension register field positions
	localparam int unsigned crt_ext_total_pos = 0;
	localparam int unsigned crt_ext_disp_pos = 2;
	localparam int unsigned crt_ext_sync_pos = 4;
	localparam int unsigned crt_ext_blank_pos = 6;
	// misc output and power bits
	localparam int unsigned crt_misc_hpol_pos = 6;
	localparam int unsigned crt_misc_vpol_pos = 7;
	localparam int unsigned crt_pm_hsync_pos = 1;
	localparam int unsigned crt_pm_vsync_pos = 2;
	localparam int unsigned crt_pm_static_clk_pos = 3;
	localparam int unsigned crt_pm_system_pos = 4;
	localparam logic [7:0] crt_pm_mask = 8'h1e;
	// reset values
	localparam logic [7:0] crt_rst_h_total = 8'h63;
	localparam logic [7:0] crt_rst_h_disp_end = 8'h4f;
	localparam logic [7:0] crt_rst_h_blank_start = 8'h50;
	localparam logic [7:0] crt_rst_h_blank_end = 8'h02;
	localparam logic [7:0] crt_rst_h_sync_start = 8'h52;
	localparam logic [7:0] crt_rst_h_sync_end = 8'h1e;
	localparam logic [7:0] crt_rst_v_total = 8'h0c;
	localparam logic [7:0] crt_rst_v_ext = 8'h7e;
	localparam logic [7:0] crt_rst_v_sync_start = 8'hea;
	localparam logic [7:0] crt_rst_v_sync_end = 8'h0c;
	localparam logic [7:0] crt_rst_v_disp_end = 8'hdf;
	localparam logic [7:0] crt_rst_v_blank_start = 8'he7;
	localparam logic [7:0] crt_rst_v_blank_end = 8'h04;
	localparam logic [7:0] crt_rst_misc = 8'h00;
	localparam logic [7:0] crt_rst_pm = 8'h00;
	// per-axis period coding
	typedef enum logic [2:0] {
		crt_ph_active = 3'b000,
		crt_ph_border_r = 3'b001,
		crt_ph_front = 3'b010,
		crt_ph_sync = 3'b011,
		crt_ph_back = 3'b100,
		crt_ph_border_l = 3'b101
	} crt_phase_t;
endpackage

//--- core/crt_char_div.sv
// Purpose: divides the pixel clock into a one-cycle character tick
// Assumes: ref_clk is the pixel clock
// Notes: held static when stop is high (static clock mode)
module crt_char_div
	import crt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic stop,
	output logic char_tick
);
	typedef struct packed {
		logic [2:0] pix;
		logic tick;
	} crt_div_t;
	crt_div_t state, next_state;

	// tick on the last pixel of each eight-pixel character
	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (!stop) begin
			next_state.pix = state.pix + 3'h1;
			next_state.tick = (state.pix == 3'(crt_pix_per_char - 1));
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign char_tick = state.tick;
endmodule

//--- core/crt_axis.sv
// Purpose: one raster axis: counter, event compares and period state
// Assumes: advance is a one-cycle step from the same clock
// Notes: end compares use only low counter bits, so periods wrap
module crt_axis
	import crt_pkg::*;
#(
	parameter int unsigned W = 8,
	parameter int unsigned SEW = 5,
	parameter int unsigned BEW = 6
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic advance,
	input wire logic [W-1:0] total,
	input wire logic [W-1:0] disp_end,
	input wire logic [W-1:0] blank_start,
	input wire logic [W-1:0] sync_start,
	input wire logic [SEW-1:0] sync_end,
	input wire logic [BEW-1:0] blank_end,
	output logic [W-1:0] count,
	output logic wrap,
	output logic disp,
	output logic blank,
	output logic sync
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic disp;
		logic blank;
		logic sync;
		crt_phase_t ph;
	} crt_ax_t;
	crt_ax_t state, next_state;
	logic [W-1:0] n;

	// counter steps, compares look at the new count value
	always_comb begin
		next_state = state;
		n = state.cnt;
		if (advance) begin
			if (state.cnt == total) begin
				n = '0;
			end else begin
				n = W'(state.cnt + 1'b1);
			end
			next_state.cnt = n;
			if (n == '0) begin
				next_state.disp = 1'b1;
				next_state.ph = crt_ph_active;
			end
			if (n == disp_end) begin
				next_state.disp = 1'b0;
				next_state.ph = crt_ph_border_r;
			end
			if (n == blank_start) begin
				next_state.blank = 1'b1;
				next_state.ph = crt_ph_front;
			end
			if (n == sync_start) begin
				next_state.sync = 1'b1;
				next_state.ph = crt_ph_sync;
			end
			if (state.sync && n[SEW-1:0] == sync_end) begin
				next_state.sync = 1'b0;
				next_state.ph = crt_ph_back;
			end
			if (state.blank && n[BEW-1:0] == blank_end) begin
				next_state.blank = 1'b0;
				next_state.ph = next_state.disp ? crt_ph_active
					: crt_ph_border_l;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= '{cnt: '0, disp: 1'b1, blank: 1'b0, sync: 1'b0,
				ph: crt_ph_active};
		end else begin
			state <= next_state;
		end
	end
	assign count = state.cnt;
	assign wrap = advance && (state.cnt == total);
	assign disp = state.disp;
	assign blank = state.blank;
	assign sync = state.sync;
endmodule

//--- core/crt_raster_timing.sv
// Purpose: raster timing generator for a crt display controller
// Assumes: plain register port, read data one cycle after the strobe
// Notes: refresh request keeps running in every power state
//
// How it works
// - the horizontal counter steps once per eight-pixel character.
// - the vertical counter steps once at the end of each scanline.
// - both counters run from zero to their total and wrap to zero.
// - horizontal count zero is the leftmost active pixel.
// - vertical count zero is the top displayed scanline.
// - six event compares per axis start the following periods.
// - a total match restarts active video on line or frame.
// - a blank end match ends blanking into border or active video.
// - sync end and blank end compare only low counter bits.
// - wide event values join an 8-bit register and extension bits.
// - each sync output takes the polarity from the misc output setting.
// - four power bits: system, static clock, static vsync, static hsync.
// - no power bit stops the display memory refresh request.
//
// Chosen here: the address-and-strobe port and the address map.
module crt_raster_timing
	import crt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] pixel_in,
	output logic [7:0] pixel_out,
	output logic hsync,
	output logic vsync,
	output logic blank_out,
	output logic dac_power_down,
	output logic refresh_req
);
	typedef struct packed {
		logic [7:0] h_total;
		logic [7:0] h_disp_end;
		logic [7:0] h_blank_start;
		logic [7:0] h_blank_end;
		logic [7:0] h_sync_start;
		logic [7:0] h_sync_end;
		logic [7:0] v_total;
		logic [7:0] v_ext;
		logic [7:0] v_sync_start;
		logic [7:0] v_sync_end;
		logic [7:0] v_disp_end;
		logic [7:0] v_blank_start;
		logic [7:0] v_blank_end;
		logic [7:0] misc;
		logic [7:0] pm;
		logic [7:0] rdata;
		logic [7:0] pix;
		logic hs;
		logic vs;
		logic blk;
		logic dac_pd;
		logic refresh;
		logic [10:0] rf_cnt;
	} crt_top_t;
	crt_top_t state, next_state;

	logic char_tick;
	logic line_tick;
	logic [7:0] h_count;
	logic [9:0] v_count;
	logic h_disp, h_blank, h_sync;
	logic v_disp, v_blank, v_sync;
	logic [9:0] v_total_full, v_disp_full, v_bstart_full, v_sstart_full;

	// joins an 8-bit primary value with two extension bits
	function automatic logic [9:0] crt_join(input logic [7:0] lo,
		input logic [7:0] ext, input int unsigned pos);
		crt_join = {ext[pos+1], ext[pos], lo};
	endfunction

	assign v_total_full = crt_join(state.v_total, state.v_ext,
		crt_ext_total_pos);
	assign v_disp_full = crt_join(state.v_disp_end, state.v_ext,
		crt_ext_disp_pos);
	assign v_sstart_full = crt_join(state.v_sync_start, state.v_ext,
		crt_ext_sync_pos);
	assign v_bstart_full = crt_join(state.v_blank_start, state.v_ext,
		crt_ext_blank_pos);

	// static clock mode freezes the character clock, not the refresh
	crt_char_div u_div (
		.ref_clk(ref_clk),
		.reset(reset),
		.stop(state.pm[crt_pm_static_clk_pos]),
		.char_tick(char_tick)
	);

	crt_axis #(
		.W(crt_h_w),
		.SEW(crt_h_sync_end_w),
		.BEW(crt_h_blank_end_w)
	) u_h (
		.ref_clk(ref_clk),
		.reset(reset),
		.advance(char_tick),
		.total(state.h_total),
		.disp_end(state.h_disp_end),
		.blank_start(state.h_blank_start),
		.sync_start(state.h_sync_start),
		.sync_end(state.h_sync_end[crt_h_sync_end_w-1:0]),
		.blank_end(state.h_blank_end[crt_h_blank_end_w-1:0]),
		.count(h_count),
		.wrap(line_tick),
		.disp(h_disp),
		.blank(h_blank),
		.sync(h_sync)
	);

	crt_axis #(
		.W(crt_v_w),
		.SEW(crt_v_sync_end_w),
		.BEW(crt_v_blank_end_w)
	) u_v (
		.ref_clk(ref_clk),
		.reset(reset),
		.advance(line_tick),
		.total(v_total_full),
		.disp_end(v_disp_full),
		.blank_start(v_bstart_full),
		.sync_start(v_sstart_full),
		.sync_end(state.v_sync_end[crt_v_sync_end_w-1:0]),
		.blank_end(state.v_blank_end),
		.count(v_count),
		.wrap(),
		.disp(v_disp),
		.blank(v_blank),
		.sync(v_sync)
	);

	// register port, video outputs and refresh request
	always_comb begin
		next_state = state;
		next_state.rdata = 8'h00;
		if (reg_write) begin
			case (reg_addr)
				crt_off_h_total: next_state.h_total = reg_wdata;
				crt_off_h_disp_end: next_state.h_disp_end = reg_wdata;
				crt_off_h_blank_start: next_state.h_blank_start = reg_wdata;
				crt_off_h_blank_end: next_state.h_blank_end = reg_wdata;
				crt_off_h_sync_start: next_state.h_sync_start = reg_wdata;
				crt_off_h_sync_end: next_state.h_sync_end = reg_wdata;
				crt_off_v_total: next_state.v_total = reg_wdata;
				crt_off_v_ext: next_state.v_ext = reg_wdata;
				crt_off_v_sync_start: next_state.v_sync_start = reg_wdata;
				crt_off_v_sync_end: next_state.v_sync_end = reg_wdata;
				crt_off_v_disp_end: next_state.v_disp_end = reg_wdata;
				crt_off_v_blank_start: next_state.v_blank_start = reg_wdata;
				crt_off_v_blank_end: next_state.v_blank_end = reg_wdata;
				crt_off_misc_output: next_state.misc = reg_wdata;
				crt_off_power_mgmt: next_state.pm = reg_wdata & crt_pm_mask;
				default: begin
				end
			endcase
		end
		if (reg_read) begin
			case (reg_addr)
				crt_off_h_total: next_state.rdata = state.h_total;
				crt_off_h_disp_end: next_state.rdata = state.h_disp_end;
				crt_off_h_blank_start: next_state.rdata = state.h_blank_start;
				crt_off_h_blank_end: next_state.rdata = state.h_blank_end;
				crt_off_h_sync_start: next_state.rdata = state.h_sync_start;
				crt_off_h_sync_end: next_state.rdata = state.h_sync_end;
				crt_off_v_total: next_state.rdata = state.v_total;
				crt_off_v_ext: next_state.rdata = state.v_ext;
				crt_off_v_sync_start: next_state.rdata = state.v_sync_start;
				crt_off_v_sync_end: next_state.rdata = state.v_sync_end;
				crt_off_v_disp_end: next_state.rdata = state.v_disp_end;
				crt_off_v_blank_start: next_state.rdata = state.v_blank_start;
				crt_off_v_blank_end: next_state.rdata = state.v_blank_end;
				crt_off_misc_output: next_state.rdata = state.misc;
				crt_off_power_mgmt: next_state.rdata = state.pm;
				crt_off_status: next_state.rdata = {3'h0, v_sync, h_sync,
					v_blank | h_blank, v_disp, h_disp};
				crt_off_h_count: next_state.rdata = h_count;
				crt_off_v_count_lo: next_state.rdata = v_count[7:0];
				crt_off_v_count_hi: next_state.rdata = {6'h00, v_count[9:8]};
				default: next_state.rdata = 8'h00;
			endcase
		end
		// polarity bit high gives an active-low pulse; static holds idle
		next_state.hs = (h_sync & ~state.pm[crt_pm_hsync_pos])
			^ state.misc[crt_misc_hpol_pos];
		next_state.vs = (v_sync & ~state.pm[crt_pm_vsync_pos])
			^ state.misc[crt_misc_vpol_pos];
		next_state.blk = h_blank | v_blank;
		next_state.dac_pd = state.pm[crt_pm_hsync_pos]
			| state.pm[crt_pm_vsync_pos];
		// data only in the display area, never in border; blank does not gate it
		next_state.pix = (h_disp && v_disp) ? pixel_in : 8'h00;
		// refresh runs off its own line-length divider, so static clock
		// mode cannot starve it; phase is not locked to the scanline
		if (state.rf_cnt >= {state.h_total, 3'(crt_pix_per_char - 1)}) begin
			next_state.rf_cnt = 11'h000;
			next_state.refresh = 1'b1;
		end else begin
			next_state.rf_cnt = state.rf_cnt + 11'h001;
			next_state.refresh = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= '{h_total: crt_rst_h_total,
				h_disp_end: crt_rst_h_disp_end,
				h_blank_start: crt_rst_h_blank_start,
				h_blank_end: crt_rst_h_blank_end,
				h_sync_start: crt_rst_h_sync_start,
				h_sync_end: crt_rst_h_sync_end,
				v_total: crt_rst_v_total, v_ext: crt_rst_v_ext,
				v_sync_start: crt_rst_v_sync_start,
				v_sync_end: crt_rst_v_sync_end,
				v_disp_end: crt_rst_v_disp_end,
				v_blank_start: crt_rst_v_blank_start,
				v_blank_end: crt_rst_v_blank_end,
				misc: crt_rst_misc, pm: crt_rst_pm,
				rdata: 8'h00, pix: 8'h00, hs: 1'b0, vs: 1'b0,
				blk: 1'b0, dac_pd: 1'b0, refresh: 1'b0,
				rf_cnt: 11'h000};
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata = state.rdata;
	assign pixel_out = state.pix;
	assign hsync = state.hs;
	assign vsync = state.vs;
	assign blank_out = state.blk;
	assign dac_power_down = state.dac_pd;
	assign refresh_req = state.refresh;
endmodule

//--- verification/crt_raster_timing_properties.sv
// Purpose: port-level checks for the raster timing generator
// Assumes: single ref_clk domain, reset asynchronous active high
// Notes: shadows of misc and power registers are rebuilt from writes
module crt_raster_timing_properties
	import crt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] pixel_in,
	input wire logic [7:0] pixel_out,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic blank_out,
	input wire logic dac_power_down,
	input wire logic refresh_req
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] pm_s;
	logic [7:0] misc_s;
	logic [2:0] age;
	logic [11:0] gap;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// age counts edges since any write; outputs settle within three
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pm_s <= crt_rst_pm;
			misc_s <= crt_rst_misc;
			age <= 3'h0;
			gap <= 12'h000;
		end else begin
			if (reg_write && reg_addr == crt_off_power_mgmt)
				pm_s <= reg_wdata & crt_pm_mask;
			if (reg_write && reg_addr == crt_off_misc_output)
				misc_s <= reg_wdata;
			age <= reg_write ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
			gap <= refresh_req ? 12'h000 : gap + 12'h001;
		end
	end
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside read slot");
	pm_read_a: assert property ($past(reg_read) &&
		$past(reg_addr) == crt_off_power_mgmt |-> reg_rdata == pm_s)
		else $error("power register read back wrong");
	pix_gate_a: assert property (pixel_out != 8'h00 |->
		pixel_out == $past(pixel_in) && !blank_out)
		else $error("pixel output not a delayed active pixel");
	hsync_static_a: assert property (age >= 3'h4 && pm_s[1] |->
		hsync == misc_s[crt_misc_hpol_pos])
		else $error("hsync not idle while static");
	vsync_static_a: assert property (age >= 3'h4 && pm_s[2] |->
		vsync == misc_s[crt_misc_vpol_pos])
		else $error("vsync not idle while static");
	dac_level_a: assert property (age >= 3'h4 |->
		dac_power_down == (pm_s[1] | pm_s[2]))
		else $error("dac power down disagrees with power bits");
	dac_cause_a: assert property ($changed(dac_power_down) |->
		age <= 3'h2)
		else $error("dac power down moved without a write");
	clock_frozen_a: assert property (age >= 3'h4 && pm_s[3] |->
		$stable(hsync) && $stable(vsync) && $stable(blank_out))
		else $error("timing outputs moved with clock static");
	hsync_tick_a: assert property (age >= 3'h4 && $changed(hsync) |=>
		($stable(hsync) || age < 3'h3) [*7])
		else $error("hsync moved off the character grid");
	blank_tick_a: assert property (age >= 3'h4 &&
		$changed(blank_out) |=> ($stable(blank_out) || age < 3'h3) [*7])
		else $error("blank moved off the character grid");
	refresh_gap_a: assert property (gap < 12'd2100)
		else $error("refresh request missing for too long");
	cover property (refresh_req && pm_s[3]);
	cover property ($rose(dac_power_down));
	cover property (pixel_out != 8'h00);
	cover property ($changed(hsync) && age >= 3'h4);
endmodule

bind crt_raster_timing crt_raster_timing_properties chk (
	.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .pixel_in(pixel_in), .pixel_out(pixel_out),
	.hsync(hsync), .vsync(vsync), .blank_out(blank_out),
	.dac_power_down(dac_power_down), .refresh_req(refresh_req)
);

//--- verification/crt_monitor_model.sv
// Purpose: monitor model measuring line, sync widths and frame pixels
// Assumes: sync active level is the output xor the chosen polarity
// Notes: line and pixel figures update at each leading sync edge, widths at the trailing edge, so read them late
module crt_monitor_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic hsync,
	input wire logic vsync,
	input wire logic hpol,
	input wire logic vpol,
	input wire logic [7:0] pixel,
	output int line_clks,
	output int hs_w,
	output int vs_w,
	output int frame_px
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ha, va, ha_q, va_q;
	int hc, hwc, vwc, pc;
	assign ha = hsync ^ hpol;
	assign va = vsync ^ vpol;
	// measure from leading edges, the only edge a real monitor trusts
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			{ha_q, va_q} <= 2'b00;
			{hc, hwc, vwc, pc} <= '0;
			{line_clks, hs_w, vs_w, frame_px} <= '0;
		end else begin
			ha_q <= ha;
			va_q <= va;
			hc <= (ha && !ha_q) ? 0 : hc + 1;
			if (ha && !ha_q)
				line_clks <= hc + 1;
			hwc <= ha ? hwc + 1 : 0;
			if (!ha && ha_q)
				hs_w <= hwc;
			vwc <= va ? vwc + 1 : 0;
			if (!va && va_q)
				vs_w <= vwc;
			pc <= (va && !va_q) ? 0 : pc + int'(pixel != 8'h00);
			if (va && !va_q)
				frame_px <= pc;
		end
	end
endmodule

//--- verification/crt_raster_timing_tb.sv
// Purpose: self-checking bench for the raster timing generator
// Assumes: registers other than the power register read back as written, pixel input never zero
// Notes: h total only grows between runs so counters never overshoot
module crt_raster_timing_tb
	import crt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, reset, reg_write, reg_read;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, pixel_in, pixel_out, misc_v, d, e;
	logic hsync, vsync, blank_out, dac_power_down, refresh_req;
	logic [31:0] seed = 32'd62833;
	int bad_count, n_tests, line_clks, hs_w, vs_w, frame_px, ht, n;
	logic [4:0] ra [15] = '{crt_off_h_total, crt_off_h_disp_end,
		crt_off_h_blank_start, crt_off_h_blank_end, crt_off_h_sync_start,
		crt_off_h_sync_end, crt_off_v_total, crt_off_v_ext,
		crt_off_v_sync_start, crt_off_v_sync_end, crt_off_v_disp_end,
		crt_off_v_blank_start, crt_off_v_blank_end, crt_off_misc_output,
		crt_off_power_mgmt};
	logic [7:0] rv [15] = '{crt_rst_h_total, crt_rst_h_disp_end,
		crt_rst_h_blank_start, crt_rst_h_blank_end, crt_rst_h_sync_start,
		crt_rst_h_sync_end, crt_rst_v_total, crt_rst_v_ext,
		crt_rst_v_sync_start, crt_rst_v_sync_end, crt_rst_v_disp_end,
		crt_rst_v_blank_start, crt_rst_v_blank_end, crt_rst_misc, crt_rst_pm};
	crt_raster_timing dut (.ref_clk(ref_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .pixel_in(pixel_in),
		.pixel_out(pixel_out), .hsync(hsync), .vsync(vsync),
		.blank_out(blank_out), .dac_power_down(dac_power_down),
		.refresh_req(refresh_req));
	crt_monitor_model mon (.ref_clk(ref_clk), .reset(reset), .hsync(hsync),
		.vsync(vsync), .hpol(misc_v[6]), .vpol(misc_v[7]), .pixel(pixel_out),
		.line_clks(line_clks), .hs_w(hs_w), .vs_w(vs_w), .frame_px(frame_px));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// clocks per line: one count step per eight-pixel character
	function automatic int exp_line(input int tot);
		return (tot + 1) * crt_pix_per_char;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	// no right border: blank start at display end; blank end at total leaves a one-step left border
	task automatic cfg(input int tot);
		wr(crt_off_h_total, 8'(tot));
		wr(crt_off_h_disp_end, 8'h04);
		wr(crt_off_h_blank_start, 8'h04);
		wr(crt_off_h_blank_end, 8'(tot));
		wr(crt_off_h_sync_start, 8'h05);
		wr(crt_off_h_sync_end, 8'he7);
		wr(crt_off_v_ext, 8'h00);
		wr(crt_off_v_total, 8'h05);
		wr(crt_off_v_sync_start, 8'h04);
		wr(crt_off_v_sync_end, 8'hf5);
		wr(crt_off_v_disp_end, 8'h03);
		wr(crt_off_v_blank_start, 8'h03);
		wr(crt_off_v_blank_end, 8'h05);
		wr(crt_off_misc_output, misc_v);
	endtask
	task automatic count_refresh(input int cyc, output int cnt);
		cnt = 0;
		repeat (cyc) begin
			@(negedge ref_clk);
			if (refresh_req === 1'b1)
				cnt++;
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		// 40 MHz pixels stay below the rate that needs half-rate doubling
		forever #12.5 ref_clk = ~ref_clk;
	end
	// random non-zero pixels so every active slot is visible
	always @(posedge ref_clk) begin
		pixel_in <= 8'(xs()) | 8'h01;
	end
	// hang guard sized well above the full sequence
	initial begin
		repeat (30000) @(posedge ref_clk);
		bad_count++;
		final_report();
	end
	initial begin
		{reset, reg_write, reg_read} = 3'b100;
		{reg_addr, reg_wdata, pixel_in, misc_v} = '0;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		for (int i = 0; i < 15; i++) begin
			rd(ra[i], d);
			check(d, rv[i]);
		end
		wr(5'h08, 8'h5a);
		rd(5'h08, d);
		check(d, 8'h00);
		misc_v = {2'(xs()), 6'h00};
		for (int i = 0; i < 3; i++) begin
			ht = 8 + i * 3 + int'(xs() % 3);
			cfg(ht);
			repeat (2400) @(posedge ref_clk);
			check(line_clks, exp_line(ht));
			check(hs_w, 2 * crt_pix_per_char);
			check(vs_w, exp_line(ht));
			check(frame_px, 4 * crt_pix_per_char * 3);
			rd(crt_off_h_count, d);
			check(d <= 8'(ht), 1'b1);
			rd(crt_off_v_count_hi, d);
			check(d, 8'h00);
			count_refresh(5 * exp_line(ht), n);
			check(n, 5);
		end
		wr(crt_off_power_mgmt, 8'hff);
		rd(crt_off_power_mgmt, d);
		check(d, crt_pm_mask);
		repeat (4) @(negedge ref_clk);
		check(dac_power_down, 1'b1);
		check(hsync, misc_v[6]);
		check(vsync, misc_v[7]);
		wr(crt_off_power_mgmt, 8'h08);
		rd(crt_off_h_count, d);
		repeat (40) @(posedge ref_clk);
		rd(crt_off_h_count, e);
		check(e, d);
		check(dac_power_down, 1'b0);
		count_refresh(400, n);
		check(n != 0, 1'b1);
		wr(crt_off_power_mgmt, 8'h00);
		repeat (40) @(posedge ref_clk);
		rd(crt_off_h_count, d);
		check(d != e, 1'b1);
		final_report();
	end
endmodule
